// ==== rtl/mbs_mem_if.sv ====
// port between the request engine and its bit and word store
// assumes both ends run on the system clock
interface mbs_mem_if;
  logic        req;
  logic        we;
  logic        word;
  logic [13:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;

  modport ctrl  (output req, we, word, addr, wdata, input  rdata);
  modport store (input  req, we, word, addr, wdata, output rdata);
endinterface

// ==== rtl/mbs_pkg.sv ====
// constants, types and address map of the serial slave responder
// assumes a single 250 MHz clock domain and whole requests delivered by a framer
package mbs_pkg;

  // function codes
  localparam logic [7:0] FC_RD_COILS  = 8'h01;
  localparam logic [7:0] FC_RD_INPUTS = 8'h02;
  localparam logic [7:0] FC_RD_HOLD   = 8'h03;
  localparam logic [7:0] FC_RD_INREG  = 8'h04;
  localparam logic [7:0] FC_WR_COIL   = 8'h05;
  localparam logic [7:0] FC_WR_REG    = 8'h06;
  localparam logic [7:0] FC_WR_COILS  = 8'h0F;
  localparam logic [7:0] FC_WR_REGS   = 8'h10;

  // exception codes
  localparam logic [7:0] EXC_FUNC  = 8'h01;
  localparam logic [7:0] EXC_ADDR  = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;

  // single-coil values
  localparam logic [15:0] COIL_SET = 16'hFF00;
  localparam logic [15:0] COIL_CLR = 16'h0000;

  // discrete address map (hex bus addresses)
  localparam logic [15:0] GLOBAL_LO          = 16'h0000;
  localparam logic [15:0] GLOBAL_HI          = 16'h05FF;
  localparam logic [15:0] OUTPUT_POINT_LO    = 16'h0800;
  localparam logic [15:0] OUTPUT_POINT_HI    = 16'h0BFF;
  localparam logic [15:0] CONTROL_RELAY_LO   = 16'h0C00;
  localparam logic [15:0] CONTROL_RELAY_HI   = 16'h13FF;
  localparam logic [15:0] TIMER_CONTACT_LO   = 16'h1800;
  localparam logic [15:0] TIMER_CONTACT_HI   = 16'h18FF;
  localparam logic [15:0] COUNTER_CONTACT_LO = 16'h1900;
  localparam logic [15:0] COUNTER_CONTACT_HI = 16'h19FF;
  localparam logic [15:0] INPUT_POINT_LO     = 16'h0800;
  localparam logic [15:0] INPUT_POINT_HI     = 16'h0BFF;
  localparam logic [15:0] SPECIAL_A_LO       = 16'h0C00;
  localparam logic [15:0] SPECIAL_A_HI       = 16'h0C5F;
  localparam logic [15:0] SPECIAL_B_LO       = 16'h0CD0;
  localparam logic [15:0] SPECIAL_B_HI       = 16'h0DCF;

  // word address map
  localparam logic [15:0] TIMER_VALUE_LO     = 16'h0000;
  localparam logic [15:0] TIMER_VALUE_HI     = 16'h00FF;
  localparam logic [15:0] COUNTER_VALUE_LO   = 16'h0200;
  localparam logic [15:0] COUNTER_VALUE_HI   = 16'h02FF;
  localparam logic [15:0] USER_A_LO          = 16'h0300;
  localparam logic [15:0] USER_A_HI          = 16'h0EFF;
  localparam logic [15:0] USER_B_LO          = 16'h1000;
  localparam logic [15:0] USER_B_HI          = 16'h3FFF;

  // storage layout
  localparam int          MEM_DEPTH    = 16384;
  localparam logic [16:0] ADDR_SPACE   = 17'h10000;
  localparam logic [7:0]  STATION_MIN  = 8'h01;
  localparam logic [7:0]  STATION_MAX  = 8'hF7;

  typedef enum logic [2:0] {
    KIND_NONE, KIND_COIL_RD, KIND_COIL_WR, KIND_INPUT, KIND_WORD_RD, KIND_WORD_WR
  } kind_t;

  typedef enum logic [2:0] {ST_IDLE, ST_CHECK, ST_READ, ST_RWAIT, ST_WDATA} state_t;

endpackage

// ==== rtl/mbs_slave.sv ====
// request engine of the serial slave: decodes, validates, reads and writes
// assumes a framer on the same clock delivers whole requests and write beats
module mbs_slave (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  // configuration
  input  wire logic [7:0]  station_i,
  output logic             slave_role_o,
  // request
  input  wire logic        req_valid_i,
  input  wire logic [7:0]  req_station_i,
  input  wire logic [7:0]  req_func_i,
  input  wire logic [15:0] req_addr_i,
  input  wire logic [15:0] req_qty_i,
  output logic             req_ready_o,
  // write data beats
  input  wire logic        wr_valid_i,
  input  wire logic [15:0] wr_data_i,
  output logic             wr_ready_o,
  // read answers
  output logic             rsp_valid_o,
  output logic [15:0]      rsp_data_o,
  output logic             rsp_last_o,
  // completion
  output logic             done_o,
  output logic             exc_o,
  output logic [7:0]       exc_code_o
);

  typedef struct packed {
    mbs_pkg::state_t st;
    mbs_pkg::kind_t  kind;
    logic [7:0]      func;
    logic [15:0]     base;
    logic [15:0]     qty;
    logic [15:0]     idx;
    logic [7:0]      station;
    logic            slave_role;
    logic            req_ready;
    logic            wr_ready;
    logic            rsp_valid;
    logic [15:0]     rsp_data;
    logic            rsp_last;
    logic            done;
    logic            exc;
    logic [7:0]      exc_code;
    logic            mem_req;
    logic            mem_we;
    logic            mem_word;
    logic [13:0]     mem_addr;
    logic [15:0]     mem_wdata;
  } state_vec_t;

  localparam state_vec_t RESET_VEC = '{
    st: mbs_pkg::ST_IDLE, kind: mbs_pkg::KIND_NONE, slave_role: 1'b1, default: '0};

  state_vec_t q;
  state_vec_t d;
  mbs_mem_if  mif ();

  mbs_store u_store (
    .clk_sys_i (clk_sys_i),
    .mem       (mif.store)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // decoding

  function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo,
                                  input logic [15:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  function automatic mbs_pkg::kind_t kind_of(input logic [7:0] fc);
    case (fc)
      mbs_pkg::FC_RD_COILS:                     return mbs_pkg::KIND_COIL_RD;
      mbs_pkg::FC_RD_INPUTS:                    return mbs_pkg::KIND_INPUT;
      mbs_pkg::FC_RD_HOLD, mbs_pkg::FC_RD_INREG: return mbs_pkg::KIND_WORD_RD;
      mbs_pkg::FC_WR_COIL, mbs_pkg::FC_WR_COILS: return mbs_pkg::KIND_COIL_WR;
      mbs_pkg::FC_WR_REG, mbs_pkg::FC_WR_REGS:   return mbs_pkg::KIND_WORD_WR;
      default:                                  return mbs_pkg::KIND_NONE;
    endcase
  endfunction

  // address check per data kind; stage bits and system words are not served
  function automatic logic addr_ok(input mbs_pkg::kind_t k, input logic [15:0] a);
    logic wr_coil;
    logic user;
    logic glob;
    wr_coil = in_rng(a, mbs_pkg::OUTPUT_POINT_LO, mbs_pkg::OUTPUT_POINT_HI)
           || in_rng(a, mbs_pkg::CONTROL_RELAY_LO, mbs_pkg::CONTROL_RELAY_HI)
           || in_rng(a, mbs_pkg::TIMER_CONTACT_LO, mbs_pkg::COUNTER_CONTACT_HI);
    user    = in_rng(a, mbs_pkg::USER_A_LO, mbs_pkg::USER_A_HI)
           || in_rng(a, mbs_pkg::USER_B_LO, mbs_pkg::USER_B_HI);
    glob    = in_rng(a, mbs_pkg::GLOBAL_LO, mbs_pkg::GLOBAL_HI);
    case (k)
      mbs_pkg::KIND_COIL_RD: return wr_coil || glob;
      mbs_pkg::KIND_COIL_WR: return wr_coil;
      mbs_pkg::KIND_INPUT:   return glob
                                 || in_rng(a, mbs_pkg::INPUT_POINT_LO, mbs_pkg::INPUT_POINT_HI)
                                 || in_rng(a, mbs_pkg::SPECIAL_A_LO, mbs_pkg::SPECIAL_A_HI)
                                 || in_rng(a, mbs_pkg::SPECIAL_B_LO, mbs_pkg::SPECIAL_B_HI);
      mbs_pkg::KIND_WORD_RD: return user
                                 || in_rng(a, mbs_pkg::TIMER_VALUE_LO, mbs_pkg::TIMER_VALUE_HI)
                                 || in_rng(a, mbs_pkg::COUNTER_VALUE_LO,
                                           mbs_pkg::COUNTER_VALUE_HI);
      mbs_pkg::KIND_WORD_WR: return user;
      default:               return 1'b0;
    endcase
  endfunction

  // inputs live in the upper half of the bit store, coils in the lower half
  function automatic logic [13:0] store_addr(input mbs_pkg::kind_t k, input logic [15:0] a);
    if (k == mbs_pkg::KIND_WORD_RD || k == mbs_pkg::KIND_WORD_WR) begin
      return a[13:0];
    end
    return {k == mbs_pkg::KIND_INPUT, a[12:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // request engine

  logic [15:0] cur_addr;
  logic        cur_last;
  logic        beat;
  logic        is_word;
  logic        mine;

  assign cur_addr = 16'(q.base + q.idx);
  assign cur_last = (q.idx == 16'(q.qty - 16'h0001));
  assign beat     = wr_valid_i && q.wr_ready;
  assign is_word  = (q.kind == mbs_pkg::KIND_WORD_RD) || (q.kind == mbs_pkg::KIND_WORD_WR);
  assign mine     = (req_station_i == q.station) && (q.station >= mbs_pkg::STATION_MIN)
                 && (q.station <= mbs_pkg::STATION_MAX);

  always_comb begin
    d           = q;
    d.rsp_valid = 1'b0;
    d.done      = 1'b0;
    d.mem_req   = 1'b0;
    d.mem_we    = 1'b0;
    d.mem_word  = is_word;
    d.mem_addr  = store_addr(q.kind, cur_addr);
    d.mem_wdata = wr_data_i;
    case (q.st)
      mbs_pkg::ST_IDLE: begin
        d.req_ready = 1'b1;
        if (req_valid_i && q.req_ready && mine) begin
          d.func  = req_func_i;
          d.kind  = kind_of(req_func_i);
          d.base  = req_addr_i;
          d.qty   = req_qty_i;
          d.idx   = 16'h0000;
          d.exc   = 1'b0;
          if (kind_of(req_func_i) == mbs_pkg::KIND_NONE) begin
            d.done     = 1'b1;
            d.exc      = 1'b1;
            d.exc_code = mbs_pkg::EXC_FUNC;
          end else if (req_qty_i == 16'h0000
                    || ({1'b0, req_addr_i} + {1'b0, req_qty_i}) > mbs_pkg::ADDR_SPACE
                    || ((req_func_i == mbs_pkg::FC_WR_COIL || req_func_i == mbs_pkg::FC_WR_REG)
                        && req_qty_i != 16'h0001)) begin
            d.done     = 1'b1;
            d.exc      = 1'b1;
            d.exc_code = mbs_pkg::EXC_VALUE;
          end else begin
            d.req_ready = 1'b0;
            d.st        = mbs_pkg::ST_CHECK;
          end
        end
      end
      mbs_pkg::ST_CHECK: begin
        // every item is checked before anything is touched
        if (!addr_ok(q.kind, cur_addr)) begin
          d.done      = 1'b1;
          d.exc       = 1'b1;
          d.exc_code  = mbs_pkg::EXC_ADDR;
          d.req_ready = 1'b1;
          d.st        = mbs_pkg::ST_IDLE;
        end else if (cur_last) begin
          d.idx = 16'h0000;
          if (q.kind == mbs_pkg::KIND_COIL_WR || q.kind == mbs_pkg::KIND_WORD_WR) begin
            d.wr_ready = 1'b1;
            d.st       = mbs_pkg::ST_WDATA;
          end else begin
            d.st = mbs_pkg::ST_READ;
          end
        end else begin
          d.idx = 16'(q.idx + 16'h0001);
        end
      end
      mbs_pkg::ST_READ: begin
        d.mem_req = 1'b1;
        d.st      = mbs_pkg::ST_RWAIT;
      end
      mbs_pkg::ST_RWAIT: begin
        d.rsp_valid = 1'b1;
        d.rsp_data  = mif.rdata;
        d.rsp_last  = cur_last;
        if (cur_last) begin
          d.done      = 1'b1;
          d.req_ready = 1'b1;
          d.st        = mbs_pkg::ST_IDLE;
        end else begin
          d.idx = 16'(q.idx + 16'h0001);
          d.st  = mbs_pkg::ST_READ;
        end
      end
      mbs_pkg::ST_WDATA: begin
        if (beat) begin
          if (q.func == mbs_pkg::FC_WR_COIL) begin
            d.mem_wdata = {15'h0000, wr_data_i == mbs_pkg::COIL_SET};
          end
          if (q.func == mbs_pkg::FC_WR_COIL && wr_data_i != mbs_pkg::COIL_SET
              && wr_data_i != mbs_pkg::COIL_CLR) begin
            d.exc      = 1'b1;
            d.exc_code = mbs_pkg::EXC_VALUE;
          end else begin
            d.mem_req = 1'b1;
            d.mem_we  = 1'b1;
          end
          if (cur_last || d.exc) begin
            d.done      = 1'b1;
            d.wr_ready  = 1'b0;
            d.req_ready = 1'b1;
            d.st        = mbs_pkg::ST_IDLE;
          end else begin
            d.idx = 16'(q.idx + 16'h0001);
          end
        end
      end
      default: begin
        d.st = mbs_pkg::ST_IDLE;
      end
    endcase
    if (rst_i) begin
      d         = RESET_VEC;
      d.station = station_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    q <= d;
  end

  // store is driven from the next-state copy so read data meet ST_RWAIT
  assign mif.req   = d.mem_req;
  assign mif.we    = d.mem_we;
  assign mif.word  = d.mem_word;
  assign mif.addr  = d.mem_addr;
  assign mif.wdata = d.mem_wdata;

  assign slave_role_o = q.slave_role;
  assign req_ready_o  = q.req_ready;
  assign wr_ready_o   = q.wr_ready;
  assign rsp_valid_o  = q.rsp_valid;
  assign rsp_data_o   = q.rsp_data;
  assign rsp_last_o   = q.rsp_last;
  assign done_o       = q.done;
  assign exc_o        = q.exc;
  assign exc_code_o   = q.exc_code;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence s_bad_func;
    req_valid_i && req_ready_o && mine && kind_of(req_func_i) == mbs_pkg::KIND_NONE;
  endsequence
  sequence s_rejected(logic [7:0] code);
    done_o && exc_o && exc_code_o == code && !rsp_valid_o;
  endsequence
  sequence s_read_issue;
    q.st == mbs_pkg::ST_READ;
  endsequence

  AST_BAD_FUNC: assert property (s_bad_func |=> s_rejected(mbs_pkg::EXC_FUNC))
    else $error("unsupported function code not rejected");
  AST_NO_WRITE_IN_CHECK: assert property (q.st == mbs_pkg::ST_CHECK |-> !mif.we)
    else $error("store written before validation ended");
  AST_COIL_WRITE_MAP: assert property (mif.we && !mif.word |->
      !mif.addr[13] && addr_ok(mbs_pkg::KIND_COIL_WR, {3'b000, mif.addr[12:0]}))
    else $error("coil write outside writable coils");
  AST_WORD_WRITE_MAP: assert property (mif.we && mif.word |->
      addr_ok(mbs_pkg::KIND_WORD_WR, {2'b00, mif.addr}))
    else $error("word write outside user data words");
  AST_READ_LATENCY: assert property (s_read_issue |-> ##2 rsp_valid_o)
    else $error("read answer not two cycles after issue");
  AST_INPUT_BANK: assert property ((s_read_issue and (q.kind == mbs_pkg::KIND_INPUT))
      |-> mif.addr[13])
    else $error("input read not in input bank");
  AST_OTHER_STATION: assert property (req_valid_i && req_ready_o && !mine
      |=> req_ready_o && !done_o)
    else $error("request for another station answered");
  AST_LAST_DONE: assert property (rsp_valid_o && rsp_last_o |-> done_o ##1 !rsp_valid_o)
    else $error("last answer without completion");
  AST_BEAT_WRITES: assert property (beat && q.func != mbs_pkg::FC_WR_COIL
      |-> mif.req && mif.we)
    else $error("write beat did not reach the store");

endmodule

// ==== rtl/mbs_store.sv ====
// bit memory (coils and inputs) and word memory of the controller
// assumes one access per cycle; read data come one cycle after the request
module mbs_store (
  // clock
  input wire logic  clk_sys_i,
  // access port
  mbs_mem_if.store  mem
);

  logic        bits_q  [mbs_pkg::MEM_DEPTH];
  logic [15:0] words_q [mbs_pkg::MEM_DEPTH];
  logic [15:0] rdata_q;

  always_ff @(posedge clk_sys_i) begin
    if (mem.req) begin
      if (mem.we && mem.word) begin
        words_q[mem.addr] <= mem.wdata;
      end
      if (mem.we && !mem.word) begin
        bits_q[mem.addr] <= mem.wdata[0];
      end
      rdata_q <= mem.word ? words_q[mem.addr] : {15'h0000, bits_q[mem.addr]};
    end
  end

  assign mem.rdata = rdata_q;

endmodule

// ==== test/mbs_master_model.sv ====
// remote master model: offers whole requests and write beats, collects answers
// assumes one caller at a time and drives everything on the falling clock edge
module mbs_master_model (
  // clock
  input  wire logic        clk_sys_i,
  // answers from the slave
  input  wire logic        req_ready_i,
  input  wire logic        wr_ready_i,
  input  wire logic        rsp_valid_i,
  input  wire logic [15:0] rsp_data_i,
  input  wire logic        rsp_last_i,
  input  wire logic        done_i,
  input  wire logic        exc_i,
  input  wire logic [7:0]  exc_code_i,
  // request and beats to the slave
  output logic             req_valid_o,
  output logic [7:0]       req_station_o,
  output logic [7:0]       req_func_o,
  output logic [15:0]      req_addr_o,
  output logic [15:0]      req_qty_o,
  output logic             wr_valid_o,
  output logic [15:0]      wr_data_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] rd_data[$];
  logic        rd_last[$];
  logic        got_done;
  logic        got_exc;
  logic [7:0]  got_code;

  initial begin
    req_valid_o   = 1'b0;
    req_station_o = 8'h00;
    req_func_o    = 8'h00;
    req_addr_o    = 16'h0000;
    req_qty_o     = 16'h0000;
    wr_valid_o    = 1'b0;
    wr_data_o     = 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one framed request, held until taken, then beats as the slave asks
  task automatic xfer(input logic [7:0] st, input logic [7:0] f, input logic [15:0] a,
                      input logic [15:0] q, input logic [15:0] wd[$], input int bound);
    int n;
    rd_data  = {};
    rd_last  = {};
    got_done = 1'b0;
    @(negedge clk_sys_i);
    req_valid_o   = 1'b1;
    req_station_o = st;
    req_func_o    = f;
    req_addr_o    = a;
    req_qty_o     = q;
    n = 0;
    while (req_ready_i !== 1'b1 && n < bound) begin
      @(negedge clk_sys_i);
      n++;
    end
    for (n = 0; n < bound && !got_done; n++) begin
      @(negedge clk_sys_i);
      if (n == 0) begin
        // released fields no longer show the last value
        req_valid_o   = 1'b0;
        req_station_o = ~req_station_o;
        req_func_o    = ~req_func_o;
        req_addr_o    = ~req_addr_o;
        req_qty_o     = ~req_qty_o;
      end
      if (rsp_valid_i === 1'b1) begin
        rd_data.push_back(rsp_data_i);
        rd_last.push_back(rsp_last_i);
      end
      if (done_i === 1'b1) begin
        got_done = 1'b1;
        got_exc  = exc_i;
        got_code = exc_code_i;
      end
      if (wr_ready_i === 1'b1 && wd.size() > 0 && !got_done) begin
        wr_valid_o = 1'b1;
        wr_data_o  = wd.pop_front();
      end else begin
        wr_valid_o = 1'b0;
        wr_data_o  = ~wr_data_o;
      end
    end
  endtask
endmodule

// ==== test/modbus_slave_address_map_bench.sv ====
// self-checking bench of the slave request engine against an associative-array reference model
// assumes the master model drives all request inputs on the falling edge
module modbus_slave_address_map_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_sys_i, rst_i, slave_role_o, req_ready_o, wr_ready_o, rsp_valid_o;
  logic        rsp_last_o, done_o, exc_o, req_valid_i, wr_valid_i;
  logic [7:0]  station_i, exc_code_o, req_station_i, req_func_i;
  logic [15:0] rsp_data_o, req_addr_i, req_qty_i, wr_data_i;
  logic        coil_m[int];
  logic [15:0] word_m[int];
  logic [15:0] no_data[$];
  int          num_errors, num_checks, own_station, f, a, q;
  int          codes[9] = '{1, 2, 3, 4, 5, 6, 15, 16, 8};
  int          vec[35][4] = '{
    '{5, 2048, 1, 0}, '{1, 2048, 1, 0}, '{5, 2048, 1, 1}, '{1, 2048, 1, 0},
    '{15, 3069, 5, 0}, '{1, 3069, 5, 0}, '{15, 5118, 2, 0}, '{15, 5119, 2, 0},
    '{5, 3116, 1, 0}, '{1, 3116, 1, 0}, '{5, 6144, 1, 0}, '{5, 6655, 1, 0},
    '{1, 6144, 512, 0}, '{1, 1535, 1, 0}, '{1, 1536, 1, 0}, '{15, 1535, 1, 0},
    '{2, 0, 1536, 0}, '{2, 3167, 2, 0}, '{2, 3280, 256, 0}, '{6, 768, 1, 0},
    '{16, 3838, 2, 0}, '{16, 3839, 2, 0}, '{16, 4095, 2, 0}, '{6, 16383, 1, 0},
    '{3, 768, 1, 0}, '{4, 3838, 2, 0}, '{4, 16383, 1, 0}, '{3, 16384, 1, 0},
    '{4, 0, 256, 0}, '{6, 0, 1, 0}, '{7, 768, 1, 0}, '{3, 768, 1, 0},
    '{6, 768, 2, 0}, '{3, 768, 0, 0}, '{1, 65535, 2, 0}};

  mbs_slave dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .station_i(station_i),
    .slave_role_o(slave_role_o), .req_valid_i(req_valid_i), .req_station_i(req_station_i),
    .req_func_i(req_func_i), .req_addr_i(req_addr_i), .req_qty_i(req_qty_i),
    .req_ready_o(req_ready_o), .wr_valid_i(wr_valid_i), .wr_data_i(wr_data_i),
    .wr_ready_o(wr_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
    .rsp_last_o(rsp_last_o), .done_o(done_o), .exc_o(exc_o), .exc_code_o(exc_code_o));

  mbs_master_model master_u (.clk_sys_i(clk_sys_i), .req_ready_i(req_ready_o),
    .wr_ready_i(wr_ready_o), .rsp_valid_i(rsp_valid_o), .rsp_data_i(rsp_data_o),
    .rsp_last_i(rsp_last_o), .done_i(done_o), .exc_i(exc_o), .exc_code_i(exc_code_o),
    .req_valid_o(req_valid_i), .req_station_o(req_station_i), .req_func_o(req_func_i),
    .req_addr_o(req_addr_i), .req_qty_o(req_qty_i), .wr_valid_o(wr_valid_i),
    .wr_data_o(wr_data_i));

  always #2 clk_sys_i = ~clk_sys_i;

  ////////////////////////////////////////////////////////////////////////////
  function automatic bit in_r(int x, int lo, int hi);
    return x >= lo && x <= hi;
  endfunction

  function automatic bit item_ok(int fc, int x);
    case (fc)
      1:       return in_r(x, 0, 1535) || in_r(x, 2048, 5119) || in_r(x, 6144, 6655);
      5, 15:   return in_r(x, 2048, 5119) || in_r(x, 6144, 6655);
      2:       return in_r(x, 0, 1535) || in_r(x, 2048, 3167) || in_r(x, 3280, 3535);
      3, 4:    return in_r(x, 0, 255) || in_r(x, 512, 3839) || in_r(x, 4096, 16383);
      default: return in_r(x, 768, 3839) || in_r(x, 4096, 16383);
    endcase
  endfunction

  function automatic int exp_code(int fc, int ad, int n, int v);
    if (!(fc inside {1, 2, 3, 4, 5, 6, 15, 16})) return 1;
    if (n == 0 || ad + n > 65536 || (fc inside {5, 6} && n != 1)) return 3;
    for (int i = 0; i < n; i++) if (!item_ok(fc, ad + i)) return 2;
    if (fc == 5 && v != 'hFF00 && v != 0) return 3;
    return 0;
  endfunction

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // one request through the model, answers compared, reference memory updated
  task automatic run(input int fc, input int ad, input int n, input int bad);
    logic [15:0] wd[$];
    int          code;
    for (int i = 0; i < n && i < 8; i++) begin
      if (fc == 5) wd.push_back(bad ? 16'h1234 : ($urandom_range(1) ? 16'hFF00 : 16'h0000));
      else if (fc == 15) wd.push_back({15'h0000, 1'($urandom_range(1))});
      else wd.push_back(16'($urandom));
    end
    code = exp_code(fc, ad, n, wd.size() > 0 ? int'(wd[0]) : 0);
    master_u.xfer(8'(own_station), 8'(fc), 16'(ad), 16'(n), wd, 5000);
    if (master_u.got_done !== 1'b1) begin
      chk_flag(1'b0, 1'b1);
      conclude();
    end
    chk_flag(master_u.got_exc, code != 0);
    if (code != 0) chk_val(16'(master_u.got_code), 16'(code));
    chk_val(16'(master_u.rd_data.size()), (code == 0 && fc < 5) ? 16'(n) : 16'h0000);
    if (code == 0 && fc < 5) chk_flag(master_u.rd_last[n-1], 1'b1);
    for (int i = 0; i < master_u.rd_data.size(); i++) begin
      chk_flag(master_u.rd_last[i], i == n - 1);
      if (fc == 1 && coil_m.exists(ad + i))
        chk_val(master_u.rd_data[i], {15'h0000, coil_m[ad + i]});
      if (fc inside {3, 4} && word_m.exists(ad + i))
        chk_val(master_u.rd_data[i], word_m[ad + i]);
    end
    for (int i = 0; i < n && code == 0; i++) begin
      if (fc == 5) coil_m[ad] = (wd[0] == 16'hFF00);
      if (fc == 15) coil_m[ad + i] = wd[i][0];
      if (fc inside {6, 16}) word_m[ad + i] = wd[i];
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys_i = 1'b0;
    rst_i     = 1'b1;
    void'($urandom(62101));
    own_station = $urandom_range(247, 1);
    station_i   = 8'(own_station);
    repeat (5) @(negedge clk_sys_i);
    chk_flag(req_ready_o, 1'b0);
    chk_flag(slave_role_o, 1'b1);
    rst_i = 1'b0;
    @(negedge clk_sys_i);
    chk_flag(slave_role_o, 1'b1);
    chk_flag(req_ready_o, 1'b1);
    foreach (vec[i]) run(vec[i][0], vec[i][1], vec[i][2], vec[i][3]);
    master_u.xfer(8'((own_station % 247) + 1), 8'h03, 16'h0300, 16'h0001, no_data, 40);
    chk_flag(master_u.got_done, 1'b0);
    chk_flag(req_ready_o, 1'b1);
    for (int k = 0; k < 40; k++) begin
      f = codes[$urandom_range(8)];
      a = (f inside {1, 2, 5, 15}) ? $urandom_range(6700) : $urandom_range(16400);
      q = (f inside {5, 6}) ? 1 : $urandom_range(4, 1);
      run(f, a, q, int'(f == 5 && $urandom_range(3) == 0));
      if (f inside {5, 15}) run(1, a, q, 0);
      if (f inside {6, 16}) run(3 + k % 2, a, q, 0);
    end
    conclude();
  end
endmodule
